/* File: membus_pkg.sv */
package membus_pkg;

	// ==========================================================
	// Identifier codes
	localparam logic [7:0] ASI_USER_INSTR  = 8'h08;
	localparam logic [7:0] ASI_USER_DATA   = 8'h0A;
	localparam logic [7:0] ASI_SUPER_INSTR = 8'h09;
	localparam logic [7:0] ASI_SUPER_DATA  = 8'h0B;

	// ==========================================================
	// Transfer size codes
	localparam logic [1:0] SIZE_BYTE   = 2'h0;
	localparam logic [1:0] SIZE_HALF   = 2'h1;
	localparam logic [1:0] SIZE_WORD   = 2'h2;
	localparam logic [1:0] SIZE_DOUBLE = 2'h3;

	// ==========================================================
	// Register map (byte addresses) and fields
	localparam logic [3:0] REG_CTRL        = 4'h0;
	localparam logic [3:0] REG_STATUS      = 4'h4;
	localparam int         CTRL_PAR_CHECK  = 0;
	localparam int         STAT_PAR_ERR    = 0;
	localparam int         STAT_MISALIGN   = 1;
	localparam int         STAT_FAULT      = 2;
	localparam int         STAT_FROZEN     = 3;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;

	// ==========================================================
	// Access kinds and cycle counts
	typedef enum logic [2:0] {
		KIND_FETCH,
		KIND_LOAD,
		KIND_STORE,
		KIND_STORE_DOUBLE,
		KIND_ATOMIC,
		KIND_IFLUSH
	} access_kind_type;

	localparam logic [1:0] CYCLES_SINGLE = 2'h1;
	localparam logic [1:0] CYCLES_STORE  = 2'h2;
	localparam logic [1:0] CYCLES_TRIPLE = 2'h3;

	// Access request from the core
	typedef struct packed {
		access_kind_type kind;
		logic [31:0]     addr;
		logic [1:0]      size;
		logic            supervisor;
		logic [31:0]     wdata;
		logic [31:0]     wdata_hi;
	} access_req_type;

	// Parameters presented on the bus for one address cycle
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0]  asi;
		logic [1:0]  size;
		logic        rd;
		logic        data_transfer_flag;
		logic        atomic;
	} bus_params_type;

endpackage

/* File: membus_if.sv */
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
// Contract
// - Address output unregistered-style; replay drives missed address (code drives address_o from a register)
// - Address and identifier float when enables deasserted
// - Address parity is odd over 32 bits
// - Address enable low drives address and identifier
// - Identifier codes for user/supervisor instruction/data
// - Replay drives missed identifier during miss hold
// - Identifier-size parity odd, floats on enables
// - Bus hold freezes pipeline; inputs held stable
// - Holds sampled at falling edge, latched
// - Control enable low drives control outputs
// - Data bus driven only for integer stores
// - Store data valid in documented data cycles
// - Misaligned accesses trap; memory 32 bits wide (code traps misaligned data accesses only; fetches are not checked)
// - Data and parity float on enables deasserted
// - Data parity odd; generated on stores, checked loads
// - Data enable low drives data bus
// - Transfer flag on every data address cycle
// - Flush trap select chooses trap or no-op
// - Nullify on store second cycle, traps, interlock, jumps
// - Atomic flag on all atomic data cycles
// - Memory holds freeze; outputs keep captured values
module membus_if (
	// Clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// Core request side
	input  wire logic                          req_valid_i,
	input  wire membus_pkg::access_req_type    req_i,
	output logic                               req_ready_o,
	input  wire logic                          trap_nullify_i,
	input  wire logic                          interlock_i,
	input  wire logic                          jump_return_i,
	output logic                               load_valid_o,
	output logic [31:0]                        load_data_o,
	output logic                               load_fault_o,
	output logic                               misalign_trap_o,
	output logic                               illegal_trap_o,
	// Enables and holds
	input  wire logic                          address_output_enable_n_i,
	input  wire logic                          control_output_enable_n_i,
	input  wire logic                          data_output_enable_n_i,
	input  wire logic                          test_output_enable_n_i,
	input  wire logic                          bus_hold_request_n_i,
	input  wire logic                          memory_hold_first_n_i,
	input  wire logic                          memory_hold_second_n_i,
	input  wire logic                          replay_missed_access_i,
	input  wire logic                          memory_data_strobe_in_n_i,
	input  wire logic                          memory_fault_in_n_i,
	input  wire logic                          flush_trap_select_i,
	// Address and identifier pins
	output logic [31:0]                        address_o,
	output logic                               address_parity_o,
	output logic [7:0]                         asi_o,
	output logic                               address_oe_o,
	output logic                               identifier_size_parity_o,
	output logic                               identifier_size_parity_oe_o,
	// Control pins
	output logic [1:0]                         size_o,
	output logic                               read_o,
	output logic                               data_transfer_flag_o,
	output logic                               atomic_access_flag_o,
	output logic                               control_oe_o,
	output logic                               cycle_nullify_o,
	// Data pins
	input  wire logic [31:0]                   data_i,
	output logic [31:0]                        data_o,
	output logic                               data_oe_o,
	input  wire logic                          data_parity_i,
	output logic                               data_parity_o,
	output logic                               data_parity_oe_o,
	// Wishbone slave
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [31:0]                   wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic [31:0]                        wb_dat_o,
	output logic                               wb_ack_o
);

	typedef enum logic [1:0] {ST_IDLE, ST_CYC1, ST_CYC2, ST_CYC3} seq_type;

	// ==========================================================
	// Helper functions
	function automatic logic odd_par32(input logic [31:0] v);
		odd_par32 = ~^v;
	endfunction

	function automatic logic misaligned(input logic [1:0] sz,
	                                    input logic [31:0] a);
		unique case (sz)
			membus_pkg::SIZE_DOUBLE: misaligned = |a[2:0];
			membus_pkg::SIZE_WORD:   misaligned = |a[1:0];
			membus_pkg::SIZE_HALF:   misaligned = a[0];
			membus_pkg::SIZE_BYTE:   misaligned = 1'b0;
		endcase
	endfunction

	seq_type                     state;
	membus_pkg::access_req_type  cur;
	membus_pkg::bus_params_type  params;
	membus_pkg::bus_params_type  miss;
	membus_pkg::bus_params_type  next_params;
	logic                        hold_latch;
	logic                        freeze;
	logic                        load_pending;
	logic                        nullify_pending;
	logic                        store_drive;
	logic [31:0]                 store_word;
	logic [31:0]                 ctrl;
	logic [3:0]                  status;
	logic                        par_err_evt;
	logic                        misalign_evt;
	logic                        fault_evt;
	logic                        start;
	logic                        wb_hit;
	logic                        drive_stage;
	logic [31:0]                 word_stage;
	logic                        second_stage;
	logic                        load_stage;

	// ==========================================================
	// Hold sampling at mid-cycle
	// Falling-edge capture stands in for the clock-high latch
	always_ff @(negedge clk_i) begin
		if (rst_i) begin
			hold_latch <= 1'b0;
		end else begin
			hold_latch <= ~bus_hold_request_n_i | ~memory_hold_first_n_i
			            | ~memory_hold_second_n_i;
		end
	end
	assign freeze = hold_latch;

	// ==========================================================
	// Request acceptance
	assign start = req_valid_i && req_ready_o && !freeze;
	assign misalign_evt = start && req_i.kind != membus_pkg::KIND_FETCH
	                    && req_i.kind != membus_pkg::KIND_IFLUSH
	                    && misaligned(req_i.size, req_i.addr);

	// Sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			cur   <= '0;
		end else if (!freeze) begin
			unique case (state)
				ST_IDLE: begin
					if (start && !misalign_evt
					    && req_i.kind != membus_pkg::KIND_IFLUSH) begin
						state <= ST_CYC1;
						cur   <= req_i;
					end
				end
				ST_CYC1: begin
					if (cur.kind == membus_pkg::KIND_FETCH
					    || cur.kind == membus_pkg::KIND_LOAD) begin
						state <= ST_IDLE;
					end else begin
						state <= ST_CYC2;
					end
				end
				ST_CYC2: begin
					state <= (cur.kind == membus_pkg::KIND_STORE) ?
					         ST_IDLE : ST_CYC3;
				end
				ST_CYC3: state <= ST_IDLE;
			endcase
		end
	end

	// Core handshake while idle or in the first cycle of a fetch or load, and not in the cycle of a start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_ready_o <= 1'b0;
		end else begin
			req_ready_o <= (state == ST_IDLE || (state == ST_CYC1
			    && (cur.kind == membus_pkg::KIND_FETCH
			    || cur.kind == membus_pkg::KIND_LOAD)))
			    && !start;
		end
	end

	// ==========================================================
	// Parameters of the current address cycle
	always_comb begin
		next_params = '0;
		if (state != ST_IDLE) begin
			next_params.addr  = cur.addr;
			next_params.size  = (cur.kind == membus_pkg::KIND_FETCH) ?
			                    membus_pkg::SIZE_WORD : cur.size;
			if (cur.kind == membus_pkg::KIND_FETCH) begin
				next_params.asi = cur.supervisor ?
				    membus_pkg::ASI_SUPER_INSTR : membus_pkg::ASI_USER_INSTR;
			end else begin
				next_params.asi = cur.supervisor ?
				    membus_pkg::ASI_SUPER_DATA : membus_pkg::ASI_USER_DATA;
			end
			next_params.data_transfer_flag  = cur.kind != membus_pkg::KIND_FETCH;
			next_params.atomic = cur.kind == membus_pkg::KIND_ATOMIC;
			next_params.rd     = !(cur.kind == membus_pkg::KIND_STORE
			    || cur.kind == membus_pkg::KIND_STORE_DOUBLE
			    || (cur.kind == membus_pkg::KIND_ATOMIC && state != ST_CYC1));
		end
	end

	// Store data: single in 2nd, double in 2nd/3rd, atomic in 3rd
	always_comb begin
		store_drive = 1'b0;
		store_word  = cur.wdata;
		unique case (cur.kind)
			membus_pkg::KIND_STORE:
				store_drive = state == ST_CYC2;
			membus_pkg::KIND_STORE_DOUBLE: begin
				store_drive = state == ST_CYC2 || state == ST_CYC3;
				store_word  = (state == ST_CYC3) ? cur.wdata_hi : cur.wdata;
			end
			membus_pkg::KIND_ATOMIC:
				store_drive = state == ST_CYC3;
			default: store_drive = 1'b0;
		endcase
	end

	// Delay data, nullify and load marks to the pin stage of params
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drive_stage  <= 1'b0;
			word_stage   <= '0;
			second_stage <= 1'b0;
			load_stage   <= 1'b0;
		end else if (!freeze) begin
			drive_stage  <= store_drive;
			word_stage   <= store_word;
			second_stage <= state == ST_CYC2
			    && cur.kind != membus_pkg::KIND_STORE_DOUBLE;
			load_stage   <= state == ST_CYC1 && next_params.rd;
		end
	end

	// Running copy of presented parameters and the missed one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			params <= '0;
			miss   <= '0;
		end else if (!freeze) begin
			params <= next_params;
			miss   <= params;
		end
	end

	// ==========================================================
	// Address, identifier and control pins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			address_o            <= '0;
			address_parity_o     <= 1'b1;
			asi_o                <= '0;
			size_o               <= '0;
			read_o               <= 1'b0;
			data_transfer_flag_o <= 1'b0;
			atomic_access_flag_o <= 1'b0;
			identifier_size_parity_o <= 1'b1;
		end else if (freeze && replay_missed_access_i) begin
			address_o            <= miss.addr;
			address_parity_o     <= odd_par32(miss.addr);
			asi_o                <= miss.asi;
			size_o               <= miss.size;
			read_o               <= miss.rd;
			data_transfer_flag_o <= miss.data_transfer_flag;
			atomic_access_flag_o <= miss.atomic;
			identifier_size_parity_o <= ~^{miss.asi, miss.size};
		end else begin
			address_o            <= params.addr;
			address_parity_o     <= odd_par32(params.addr);
			asi_o                <= params.asi;
			size_o               <= params.size;
			read_o               <= params.rd;
			data_transfer_flag_o <= params.data_transfer_flag;
			atomic_access_flag_o <= params.atomic;
			identifier_size_parity_o <= ~^{params.asi, params.size};
		end
	end

	// Output enables follow the active-low enable inputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			address_oe_o                <= 1'b0;
			control_oe_o                <= 1'b0;
			identifier_size_parity_oe_o <= 1'b0;
		end else begin
			address_oe_o <= !address_output_enable_n_i
			              && !test_output_enable_n_i;
			control_oe_o <= !control_output_enable_n_i
			              && !test_output_enable_n_i;
			identifier_size_parity_oe_o <= !address_output_enable_n_i
			    && !control_output_enable_n_i
			    && !test_output_enable_n_i;
		end
	end

	// ==========================================================
	// Data pins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_o           <= '0;
			data_parity_o    <= 1'b1;
			data_oe_o        <= 1'b0;
			data_parity_oe_o <= 1'b0;
		end else if (!freeze) begin
			data_o           <= word_stage;
			data_parity_o    <= odd_par32(word_stage);
			data_oe_o        <= drive_stage && !data_output_enable_n_i
			                  && !test_output_enable_n_i;
			data_parity_oe_o <= drive_stage && !data_output_enable_n_i
			                  && !test_output_enable_n_i;
		end else if (data_output_enable_n_i || test_output_enable_n_i) begin
			data_oe_o        <= 1'b0;
			data_parity_oe_o <= 1'b0;
		end
	end

	// ==========================================================
	// Load data capture and parity check
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			load_pending <= 1'b0;
			load_valid_o <= 1'b0;
			load_data_o  <= '0;
			load_fault_o <= 1'b0;
		end else begin
			load_valid_o <= 1'b0;
			load_fault_o <= 1'b0;
			if (load_pending && (!freeze || !memory_data_strobe_in_n_i)) begin
				load_pending <= 1'b0;
				load_valid_o <= memory_fault_in_n_i;
				load_fault_o <= !memory_fault_in_n_i;
				load_data_o  <= data_i;
			end
			if (!freeze && load_stage && !nullify_pending) begin
				load_pending <= 1'b1;
			end
		end
	end
	assign par_err_evt = load_pending && (!freeze
	    || !memory_data_strobe_in_n_i) && memory_fault_in_n_i
	    && ctrl[membus_pkg::CTRL_PAR_CHECK]
	    && (odd_par32(data_i) != data_parity_i);
	assign fault_evt = load_pending && !freeze ? 1'b0 :
	    load_pending && !memory_data_strobe_in_n_i && !memory_fault_in_n_i;

	// ==========================================================
	// Nullify, misalignment and flush traps
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nullify_pending <= 1'b0;
			cycle_nullify_o <= 1'b0;
		end else if (!freeze) begin
			nullify_pending <= trap_nullify_i || interlock_i
			                 || jump_return_i;
			cycle_nullify_o <= nullify_pending || second_stage;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			misalign_trap_o <= 1'b0;
			illegal_trap_o  <= 1'b0;
		end else begin
			misalign_trap_o <= misalign_evt;
			illegal_trap_o  <= start && req_i.kind == membus_pkg::KIND_IFLUSH
			                 && !flush_trap_select_i;
		end
	end

	// ==========================================================
	// Wishbone slave: control, sticky status bits 0 to 2 and live frozen bit
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= '0;
			if (wb_hit && !wb_we_i) begin
				unique case (wb_adr_i[3:0])
					membus_pkg::REG_CTRL:   wb_dat_o <= ctrl;
					membus_pkg::REG_STATUS: wb_dat_o <= {28'h000_0000, status};
					default:                wb_dat_o <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= membus_pkg::CTRL_RESET;
		end else if (wb_hit && wb_we_i && wb_sel_i[0]
		             && wb_adr_i[3:0] == membus_pkg::REG_CTRL) begin
			ctrl <= {31'h0000_0000, wb_dat_i[membus_pkg::CTRL_PAR_CHECK]};
		end
	end

	// Write one to clear; a new event wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status <= '0;
		end else begin
			if (wb_hit && wb_we_i && wb_sel_i[0]
			    && wb_adr_i[3:0] == membus_pkg::REG_STATUS) begin
				status[2:0] <= status[2:0] & ~wb_dat_i[2:0];
			end
			if (par_err_evt) status[membus_pkg::STAT_PAR_ERR] <= 1'b1;
			if (misalign_evt) status[membus_pkg::STAT_MISALIGN] <= 1'b1;
			if (fault_evt) status[membus_pkg::STAT_FAULT] <= 1'b1;
			status[membus_pkg::STAT_FROZEN] <= freeze;
		end
	end

	// ==========================================================
	// Checks
	property p_addr_par;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> (^{address_o, address_parity_o}) == 1'b1;
	endproperty
	a_addr_par: assert property (p_addr_par)
		else $error("address parity not odd");

	property p_id_par;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> (^{asi_o, size_o, identifier_size_parity_o}) == 1'b1;
	endproperty
	a_id_par: assert property (p_id_par)
		else $error("identifier size parity not odd");

	property p_data_write;
		@(posedge clk_i) disable iff (rst_i)
		data_oe_o |-> !read_o && data_transfer_flag_o;
	endproperty
	a_data_write: assert property (p_data_write)
		else $error("data bus driven outside store");

	property p_store_null;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_CYC2 && cur.kind == membus_pkg::KIND_STORE && !freeze)
		##1 !freeze |=> cycle_nullify_o;
	endproperty
	a_store_null: assert property (p_store_null)
		else $error("store second cycle not nullified");

	property p_replay;
		@(posedge clk_i) disable iff (rst_i)
		(freeze && replay_missed_access_i) |=> address_o == $past(miss.addr);
	endproperty
	a_replay: assert property (p_replay)
		else $error("missed address not replayed");

	property p_freeze;
		@(posedge clk_i) disable iff (rst_i)
		freeze |=> $stable(state) && $stable(params);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while frozen");

	property p_misalign;
		@(posedge clk_i) disable iff (rst_i)
		(start && req_i.kind == membus_pkg::KIND_LOAD
		 && req_i.size == membus_pkg::SIZE_WORD && req_i.addr[0])
		|=> misalign_trap_o ##1 !misalign_trap_o;
	endproperty
	a_misalign: assert property (p_misalign)
		else $error("misaligned word not trapped");

	property p_flush;
		@(posedge clk_i) disable iff (rst_i)
		(start && req_i.kind == membus_pkg::KIND_IFLUSH)
		|=> illegal_trap_o == !$past(flush_trap_select_i);
	endproperty
	a_flush: assert property (p_flush)
		else $error("flush trap select ignored");

	property p_addr_oe;
		@(posedge clk_i) disable iff (rst_i)
		(address_output_enable_n_i || test_output_enable_n_i)
		|=> !address_oe_o && !identifier_size_parity_oe_o;
	endproperty
	a_addr_oe: assert property (p_addr_oe)
		else $error("address drivers not released");

	property p_atomic;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_CYC1 && cur.kind == membus_pkg::KIND_ATOMIC && !freeze)
		|=> ##1 atomic_access_flag_o;
	endproperty
	a_atomic: assert property (p_atomic)
		else $error("atomic flag missing");

endmodule

/* File: membus_mem.sv */
`timescale 1ns/1ps
// ====
// Memory side model
module membus_mem (
	// Pins of the block
	input  wire logic [31:0] address_i,
	input  wire logic        read_i,
	input  wire logic        xfer_i,
	input  wire logic        dev_oe_i,
	input  wire logic [31:0] dev_d_i,
	input  wire logic        dev_p_i,
	// Answers to the block
	output logic [31:0]      data_o,
	output logic             parity_o,
	output logic             strobe_n_o,
	output logic             fault_n_o,
	output logic             hold_n_o
);
	// Wire level: block drives, memory answers a read, else pull-ups
	always_comb begin
		if (dev_oe_i) begin
			data_o = dev_d_i;
			parity_o = dev_p_i;
		end else begin
			data_o = !read_i ? 32'hFFFF_FFFF : address_i
			    ^ (xfer_i ? 32'hA5A5_5A5A : 32'h5A5A_A5A5);
			parity_o = ~^data_o;
		end
	end
	// No strobe or fault, so nullified cycles stay clean
	assign strobe_n_o = 1'b1;
	assign fault_n_o = 1'b1;
	assign hold_n_o = 1'b1;
endmodule

/* File: membus_if_tb.sv */
`timescale 1ns/1ps
module membus_if_tb;
	// ====
	// Signals
	logic clk_i = 0, rst_i = 1, req_valid_i = 0, flush_trap_select_i = 0;
	logic trap_nullify_i = 0, interlock_i = 0, jump_return_i = 0;
	logic address_output_enable_n_i = 0, control_output_enable_n_i = 0;
	logic data_output_enable_n_i = 0, test_output_enable_n_i = 0;
	logic bus_hold_request_n_i = 1, memory_hold_first_n_i = 1;
	logic replay_missed_access_i = 0;
	logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [31:0] wb_adr_i = '0, wb_dat_i = '0;
	logic [3:0] wb_sel_i = 4'hF;
	membus_pkg::access_req_type req_i = '0;
	logic req_ready_o, load_valid_o, load_fault_o, misalign_trap_o;
	logic illegal_trap_o, address_parity_o, address_oe_o, read_o;
	logic identifier_size_parity_o, identifier_size_parity_oe_o;
	logic data_transfer_flag_o, atomic_access_flag_o, control_oe_o;
	logic cycle_nullify_o, data_oe_o, data_parity_o, data_parity_oe_o;
	logic wb_ack_o, data_parity_i, memory_data_strobe_in_n_i;
	logic memory_fault_in_n_i, memory_hold_second_n_i;
	logic [31:0] load_data_o, address_o, data_o, data_i, wb_dat_o;
	logic [7:0] asi_o;
	logic [1:0] size_o;
	logic [31:0] exp_q[$];
	int errors = 0, n_tests = 0;
	// Clock
	always #5 clk_i = ~clk_i;
	membus_if u_membus_if (.clk_i, .rst_i, .req_valid_i, .req_i, .req_ready_o,
		.trap_nullify_i, .interlock_i, .jump_return_i, .load_valid_o,
		.load_data_o, .load_fault_o, .misalign_trap_o, .illegal_trap_o,
		.address_output_enable_n_i, .control_output_enable_n_i,
		.data_output_enable_n_i, .test_output_enable_n_i, .bus_hold_request_n_i,
		.memory_hold_first_n_i, .memory_hold_second_n_i,
		.replay_missed_access_i, .memory_data_strobe_in_n_i,
		.memory_fault_in_n_i, .flush_trap_select_i, .address_o,
		.address_parity_o, .asi_o, .address_oe_o, .identifier_size_parity_o,
		.identifier_size_parity_oe_o, .size_o, .read_o, .data_transfer_flag_o,
		.atomic_access_flag_o, .control_oe_o, .cycle_nullify_o, .data_i,
		.data_o, .data_oe_o, .data_parity_i, .data_parity_o, .data_parity_oe_o,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o);
	membus_mem u_membus_mem (.address_i(address_o), .read_i(read_o),
		.xfer_i(data_transfer_flag_o), .dev_oe_i(data_oe_o), .dev_d_i(data_o),
		.dev_p_i(data_parity_o), .data_o(data_i), .parity_o(data_parity_i),
		.strobe_n_o(memory_data_strobe_in_n_i), .fault_n_o(memory_fault_in_n_i),
		.hold_n_o(memory_hold_second_n_i));
	// ====
	// Checking
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Results take the oldest note
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && !wb_we_i) chk(wb_dat_o, exp_q.pop_front());
		else if (load_valid_o === 1'b1) chk(load_data_o, exp_q.pop_front());
		else if ((misalign_trap_o | illegal_trap_o | load_fault_o) === 1'b1)
			chk({load_fault_o, misalign_trap_o, illegal_trap_o},
				exp_q.pop_front());
	end
	// ====
	// Bus tasks
	task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
		int k;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
		if (k == 20) begin
			errors++;
			print_verdict();
		end
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic access(input int kn, input logic [31:0] a, input logic [1:0] sz);
		membus_pkg::access_kind_type kd;
		logic sp, nul, data_output_enable;
		logic [31:0] wd, wh, d;
		logic [7:0] asi;
		int k, n;
		kd = membus_pkg::access_kind_type'(kn);
		sp = 1'($urandom);
		wd = $urandom;
		wh = $urandom;
		for (k = 0; k < 50 && req_ready_o !== 1'b1; k++) @(posedge clk_i);
		if (k == 50) begin
			errors++;
			print_verdict();
		end
		req_valid_i <= 1'b1;
		req_i <= '{kd, a, sz, sp, wd, wh};
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		if (kd == membus_pkg::KIND_IFLUSH) begin
			if (!flush_trap_select_i) exp_q.push_back(32'h1);
			repeat (4) @(posedge clk_i);
			return;
		end
		if (kd != membus_pkg::KIND_FETCH && (a & ((32'h1 << sz) - 1)) != 0) begin
			exp_q.push_back(32'h2);
			repeat (4) @(posedge clk_i);
			return;
		end
		n = (kd < 2) ? 1 : (kd == membus_pkg::KIND_STORE) ? 2 : 3;
		if (kd < 2 || kd == membus_pkg::KIND_ATOMIC)
			exp_q.push_back(a ^ (kd == 0 ? 32'h5A5A_A5A5 : 32'hA5A5_5A5A));
		asi = (kd == membus_pkg::KIND_FETCH) ? {7'h04, sp} : {6'h02, 1'b1, sp};
		if (kd == membus_pkg::KIND_FETCH) sz = membus_pkg::SIZE_WORD;
		repeat (2) @(posedge clk_i);
		for (k = 0; k < n; k++) begin
			#1;
			nul = k == 1 && kd != membus_pkg::KIND_STORE_DOUBLE;
			data_output_enable = kd > 1 && (k == 2 || (k == 1 && kd != membus_pkg::KIND_ATOMIC));
			d = (kd == membus_pkg::KIND_STORE_DOUBLE && k == 2) ? wh : wd;
			chk(address_o, a);
			chk(address_parity_o, ~^a);
			chk(asi_o, asi);
			chk({size_o, identifier_size_parity_o}, {sz, ~^{asi, sz}});
			chk({data_transfer_flag_o, atomic_access_flag_o, cycle_nullify_o},
				{kd != 0, kd == membus_pkg::KIND_ATOMIC, nul});
			chk({read_o, data_oe_o}, {kd < 2 || (kd == 4 && k == 0), data_output_enable});
			if (data_output_enable) chk({data_o, data_parity_o}, {d, ~^d});
			@(posedge clk_i);
		end
		repeat (3) @(posedge clk_i);
	endtask
	// ====
	// Main sequence
	initial begin
		int i;
		void'($urandom(62625));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		exp_q.push_back(32'h1);
		wb(0, 32'h0, 0);
		exp_q.push_back(32'h0);
		wb(0, 32'h8, 0);
		wb(1, 32'h0, 32'h0);
		exp_q.push_back(32'h0);
		wb(0, 32'h0, 0);
		wb(1, 32'h0, 32'h1);
		for (i = 0; i < 12; i++)
			access(i % 6, $urandom & 32'hFFFF_FFF8, (i % 6 == 3) ? 2'h3 : 2'($urandom_range(2)));
		flush_trap_select_i <= 1'b1;
		access(5, 32'h0, 2'h2);
		access(2, 32'h0000_1001, 2'h1);
		access(1, 32'h0000_2003, 2'h2);
		access(3, 32'h0000_3004, 2'h3);
		for (i = 0; i < 3; i++) begin
			{trap_nullify_i, interlock_i, jump_return_i} <= 3'b100 >> i;
			@(posedge clk_i);
			{trap_nullify_i, interlock_i, jump_return_i} <= 3'b000;
			@(posedge clk_i);
			#1 chk(cycle_nullify_o, 1'b1);
		end
		for (i = 0; i < 3; i++) begin
			@(posedge clk_i);
			{bus_hold_request_n_i, memory_hold_first_n_i} <= (i == 0) ? 2'b01 : 2'b10;
			replay_missed_access_i <= i == 1;
			{address_output_enable_n_i, control_output_enable_n_i} <= 2'b11;
			data_output_enable_n_i <= 1'b1;
			if (i == 2) {bus_hold_request_n_i, memory_hold_first_n_i} <= 2'b11;
			if (i == 2) {address_output_enable_n_i, control_output_enable_n_i} <= 2'b00;
			if (i == 2) data_output_enable_n_i <= 1'b0;
			test_output_enable_n_i <= i == 2;
			repeat (3) @(posedge clk_i);
			#1 chk({address_oe_o, identifier_size_parity_oe_o, control_oe_o,
				data_oe_o, data_parity_oe_o}, 5'h00);
			exp_q.push_back(i == 2 ? 32'h2 : 32'hA);
			wb(0, 32'h4, 0);
			{bus_hold_request_n_i, memory_hold_first_n_i} <= 2'b11;
			replay_missed_access_i <= 1'b0;
			{address_output_enable_n_i, control_output_enable_n_i} <= 2'b00;
			{data_output_enable_n_i, test_output_enable_n_i} <= 2'b00;
			repeat (3) @(posedge clk_i);
			#1 chk({address_oe_o, control_oe_o}, 2'b11);
		end
		access(2, 32'h0000_0040, 2'h2);
		print_verdict();
	end
endmodule
